// ### rtl/mq_read_port.sv
// read port of a 32-queue fifo device with flag bus and axi4-lite control
`default_nettype none
module mq_read_port (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [7:0]  READ_QUEUE_ADDRESS,
  input  wire logic        READ_ADDRESS_STROBE,
  input  wire logic        FLAG_QUADRANT_STROBE,
  input  wire logic        READ_ENABLE_N,
  input  wire logic        OUTPUT_ENABLE_N,
  input  wire logic        EXPANSION_IN,
  output var  logic [35:0] READ_DATA,
  output var  logic        OUTPUT_VALID_FLAG_N,
  output var  logic        ALMOST_EMPTY_FLAG_N,
  output var  logic        PACKET_READY_FLAG_N,
  output var  logic [7:0]  ALMOST_EMPTY_READY_BUS_N,
  output var  logic        FLAG_BUS_SYNC,
  output var  logic        EXPANSION_OUT,
  output var  logic        PROGRAM_DONE_OUT_N,
  output var  logic        IRQ,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  output var  logic [1:0]  BRESP,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  input  wire logic [7:0]  ARADDR,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] addr_s;
  logic       sel_stb_s;
  logic       quad_stb_s;
  logic       ren_n_s;
  logic       oe_n_s;
  logic       exp_in_s;

  // strobes and address share one delay so they stay aligned
  pin_sync #(.WIDTH(mq_read_pkg::PIN_SYNC_W)) u_pin_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .d   ({READ_QUEUE_ADDRESS, READ_ADDRESS_STROBE, FLAG_QUADRANT_STROBE,
           READ_ENABLE_N, OUTPUT_ENABLE_N, EXPANSION_IN}),
    .q   ({addr_s, sel_stb_s, quad_stb_s, ren_n_s, oe_n_s, exp_in_s})
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] levels;
  logic [31:0] irq_mask;
  logic [31:0] irq_status;
  logic [31:0] push_lo;

  wire       poll_mode  = ctrl[mq_read_pkg::CTRL_POLL_BIT];
  wire [2:0] device_id  = ctrl[mq_read_pkg::CTRL_ID_LSB +: mq_read_pkg::DEV_W];
  wire       programmed = ctrl[mq_read_pkg::CTRL_DONE_BIT];
  wire [2:0] ae_level   = levels[mq_read_pkg::LVL_AE_LSB +: mq_read_pkg::CNT_W];
  wire [2:0] pr_level   = levels[mq_read_pkg::LVL_PR_LSB +: mq_read_pkg::CNT_W];

  // ----------------------------------------------------------------
  // selection decode
  // ----------------------------------------------------------------
  logic [4:0] sel_queue;
  logic [1:0] quadrant;
  logic       q_sel;
  logic       first_word_fallthrough_pend;
  logic       ov_n;

  wire id_match    = addr_s[7:5] == device_id;
  // both strobes at once is illegal; neither is honoured then
  wire sel_strobe  = sel_stb_s & ~quad_stb_s & programmed;
  wire sel_take    = sel_strobe & id_match;
  wire sel_other   = sel_strobe & ~id_match;
  wire quad_take   = quad_stb_s & ~sel_stb_s & programmed & id_match & ~poll_mode;
  wire rd_ok       = ~ren_n_s & ~oe_n_s & q_sel;

  // ----------------------------------------------------------------
  // queue storage
  // ----------------------------------------------------------------
  logic [35:0] mem [mq_read_pkg::QUEUES*mq_read_pkg::DEPTH];
  logic [2:0]  cnt  [mq_read_pkg::QUEUES];
  logic [1:0]  head [mq_read_pkg::QUEUES];
  logic [1:0]  tail [mq_read_pkg::QUEUES];
  logic [31:0] ae_vec;

  logic        push;
  logic [4:0]  push_q;
  logic [35:0] push_word;

  wire [2:0]  sel_cnt   = cnt[sel_queue];
  wire [35:0] head_word = mem[{sel_queue, head[sel_queue]}];
  wire        push_full = cnt[push_q] == 3'(mq_read_pkg::DEPTH);
  wire        push_ok   = push & ~push_full;
  // first_word_fallthrough reload and refill of an empty output (ov_n high) ignore the enables; reads of a valid word need all enables
  wire        load      = q_sel & (first_word_fallthrough_pend | rd_ok | ov_n);
  wire        pop       = load & (sel_cnt != 3'h0);
  wire        underflow = rd_ok & ov_n & ~first_word_fallthrough_pend;

  for (genvar g = 0; g < mq_read_pkg::QUEUES; g++) begin : g_flag
    assign ae_vec[g] = cnt[g] <= ae_level;
  end

  always_ff @(posedge CLK_SYS) begin
    if (push_ok) begin
      mem[{push_q, tail[push_q]}] <= push_word;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < mq_read_pkg::QUEUES; i++) begin
        cnt[i]  <= 3'h0;
        head[i] <= 2'h0;
        tail[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < mq_read_pkg::QUEUES; i++) begin
        cnt[i] <= cnt[i] + 3'(push_ok && push_q == 5'(i)) - 3'(pop && sel_queue == 5'(i));
      end
      if (push_ok) begin
        tail[push_q] <= tail[push_q] + 2'h1;
      end
      if (pop) begin
        head[sel_queue] <= head[sel_queue] + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sel_queue <= 5'h00;
      q_sel     <= 1'b0;
      first_word_fallthrough_pend <= 1'b0;
    end else begin
      if (sel_take) begin
        sel_queue <= addr_s[4:0];
        q_sel     <= 1'b1;
      end else if (sel_other) begin
        q_sel <= 1'b0;
      end
      first_word_fallthrough_pend <= sel_take;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      READ_DATA <= 36'h0_0000_0000;
      ov_n      <= 1'b1;
    end else if (load) begin
      if (pop) begin
        READ_DATA <= head_word;
      end
      ov_n <= ~pop;
    end else if (!q_sel) begin
      ov_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // flags and flag bus
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      quadrant                 <= 2'h0;
      ALMOST_EMPTY_READY_BUS_N <= 8'hff;
      FLAG_BUS_SYNC            <= 1'b0;
      ALMOST_EMPTY_FLAG_N      <= 1'b1;
      PACKET_READY_FLAG_N      <= 1'b1;
      OUTPUT_VALID_FLAG_N      <= 1'b1;
      EXPANSION_OUT            <= 1'b0;
      PROGRAM_DONE_OUT_N       <= 1'b1;
    end else begin
      if (poll_mode) begin
        quadrant <= quadrant + 2'h1;
      end else if (quad_take) begin
        quadrant <= addr_s[1:0];
      end
      ALMOST_EMPTY_READY_BUS_N <= ~ae_vec[{quadrant, 3'h0} +: mq_read_pkg::FLAG_BUS_W];
      FLAG_BUS_SYNC            <= poll_mode & (quadrant == 2'h0);
      ALMOST_EMPTY_FLAG_N      <= ~(q_sel & ae_vec[sel_queue]);
      PACKET_READY_FLAG_N      <= ~(q_sel & (sel_cnt >= pr_level));
      OUTPUT_VALID_FLAG_N      <= ov_n;
      EXPANSION_OUT            <= q_sel & ~exp_in_s;
      PROGRAM_DONE_OUT_N       <= ~programmed;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  wire do_write  = ~AWREADY & ~WREADY & ~BVALID;
  wire wr_ctrl   = do_write & (wr_addr == mq_read_pkg::OFS_CTRL);
  wire wr_clear  = do_write & (wr_addr == mq_read_pkg::OFS_IRQ_STATUS);
  wire wr_mask   = do_write & (wr_addr == mq_read_pkg::OFS_IRQ_MASK);
  wire wr_lo     = do_write & (wr_addr == mq_read_pkg::OFS_PUSH_LO);
  wire wr_cmd    = do_write & (wr_addr == mq_read_pkg::OFS_PUSH_CMD);
  wire wr_lvl    = do_write & (wr_addr == mq_read_pkg::OFS_LEVELS);
  wire wr_mapped = wr_ctrl | wr_clear | wr_mask | wr_lo | wr_cmd | wr_lvl;
  wire [31:0] bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wbits = wr_data & bmask;

  wire [31:0] status_word = {22'h00_0000, ~ov_n, exp_in_s, quadrant, q_sel, sel_queue};
  wire rd_ctrl   = ARADDR == mq_read_pkg::OFS_CTRL;
  wire rd_status = ARADDR == mq_read_pkg::OFS_STATUS;
  wire rd_irq    = ARADDR == mq_read_pkg::OFS_IRQ_STATUS;
  wire rd_mask   = ARADDR == mq_read_pkg::OFS_IRQ_MASK;
  wire rd_lo     = ARADDR == mq_read_pkg::OFS_PUSH_LO;
  wire rd_cmd    = ARADDR == mq_read_pkg::OFS_PUSH_CMD;
  wire rd_lvl    = ARADDR == mq_read_pkg::OFS_LEVELS;
  wire rd_mapped = rd_ctrl | rd_status | rd_irq | rd_mask | rd_lo | rd_cmd | rd_lvl;
  // push command register reads as zero; it only acts on write
  wire [31:0] rd_mux = rd_ctrl ? ctrl : rd_status ? status_word : rd_irq ? irq_status :
                       rd_mask ? irq_mask : rd_lo ? push_lo : rd_lvl ? levels : 32'h0000_0000;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      BVALID  <= 1'b0;
      BRESP   <= mq_read_pkg::RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        wr_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wr_data <= WDATA;
        wr_strb <= WSTRB;
        WREADY  <= 1'b0;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP  <= wr_mapped ? mq_read_pkg::RESP_OKAY : mq_read_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= mq_read_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_mux;
      RRESP   <= rd_mapped ? mq_read_pkg::RESP_OKAY : mq_read_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register file and interrupts
  // ----------------------------------------------------------------
  wire [2:0] events = {push & push_full, underflow, sel_take};

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl       <= mq_read_pkg::CTRL_RST;
      levels     <= mq_read_pkg::LEVELS_RST;
      irq_mask   <= mq_read_pkg::MASK_RST;
      irq_status <= 32'h0000_0000;
      push_lo    <= 32'h0000_0000;
      push       <= 1'b0;
      push_q     <= 5'h00;
      push_word  <= 36'h0_0000_0000;
      IRQ        <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= (ctrl & ~bmask) | wbits;
      if (wr_lvl) levels <= (levels & ~bmask) | wbits;
      if (wr_mask) irq_mask <= (irq_mask & ~bmask) | wbits;
      if (wr_lo) push_lo <= (push_lo & ~bmask) | wbits;
      // a new event wins over a write-one clear in the same cycle
      irq_status <= (irq_status & ~(wr_clear ? wbits : 32'h0000_0000)) | {29'h0000_0000, events};
      push      <= wr_cmd;
      push_q    <= wr_data[mq_read_pkg::CMD_QUEUE_LSB +: mq_read_pkg::QUEUE_AW];
      push_word <= {wr_data[mq_read_pkg::CMD_HI_LSB +: 4], push_lo};
      IRQ       <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  queue_capture_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    sel_take |=> q_sel && sel_queue == $past(addr_s[4:0]) ##1 !first_word_fallthrough_pend)
    else $error("queue selection not captured");
  foreign_id_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    sel_other |=> !q_sel && sel_queue == $past(sel_queue))
    else $error("selection for another device was taken");
  first_word_fallthrough_first_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    sel_take ##1 (sel_cnt != 3'h0) |=> !ov_n ##1 !OUTPUT_VALID_FLAG_N)
    else $error("first word did not fall through");
  read_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    pop && !ov_n && !first_word_fallthrough_pend |-> !ren_n_s && !oe_n_s && q_sel)
    else $error("word read without enables");
  quad_select_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    quad_take |=> quadrant == $past(addr_s[1:0]))
    else $error("quadrant not captured");
  poll_step_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    poll_mode && quadrant == 2'h0 |=> FLAG_BUS_SYNC && quadrant == 2'h1 ##1 !FLAG_BUS_SYNC)
    else $error("polled flag bus did not step");
  flag_update_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    q_sel && ae_vec[sel_queue] |=> !ALMOST_EMPTY_FLAG_N)
    else $error("almost empty flag late");
  expansion_out_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    exp_in_s |=> !EXPANSION_OUT)
    else $error("expansion output driven while other device owns port");
  irq_level_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    sel_take && irq_mask[mq_read_pkg::EV_SELECT] |=> ##1 IRQ)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// ### rtl/mq_read_pkg.sv
// constants shared by the multi-queue read port design
`default_nettype none
package mq_read_pkg;
  // ----------------------------------------------------------------
  // queue geometry
  // ----------------------------------------------------------------
  localparam int unsigned QUEUES      = 32;
  localparam int unsigned QUEUE_AW    = 5;
  localparam int unsigned SLOT_AW     = 2;
  localparam int unsigned DEPTH       = 4;
  localparam int unsigned WORD_W      = 36;
  localparam int unsigned CNT_W       = 3;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DEV_W       = 3;
  localparam int unsigned QUAD_W      = 2;
  localparam int unsigned FLAG_BUS_W  = 8;
  localparam int unsigned PIN_SYNC_W  = 13;
  localparam int unsigned EVENT_W     = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] OFS_PUSH_LO    = 8'h10;
  localparam logic [7:0] OFS_PUSH_CMD   = 8'h14;
  localparam logic [7:0] OFS_LEVELS     = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_POLL_BIT  = 0;
  localparam int unsigned CTRL_ID_LSB    = 1;
  localparam int unsigned CTRL_DONE_BIT  = 4;
  localparam int unsigned CMD_HI_LSB     = 0;
  localparam int unsigned CMD_QUEUE_LSB  = 8;
  localparam int unsigned LVL_AE_LSB     = 0;
  localparam int unsigned LVL_PR_LSB     = 4;
  localparam int unsigned EV_SELECT      = 0;
  localparam int unsigned EV_UNDERFLOW   = 1;
  localparam int unsigned EV_OVERFLOW    = 2;

  // ----------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] LEVELS_RST = 32'h0000_0031;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire  logic             clk,
  input  wire  logic             rst,
  input  wire  logic [WIDTH-1:0] d,
  output var   logic [WIDTH-1:0] q
);
  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ### dv/host_read_model.sv
// host-side pin model that drives the read port of the queue device
`default_nettype none
module host_read_model (
  input  wire logic       clk,
  output var  logic [7:0] queue_address,
  output var  logic       address_strobe,
  output var  logic       quadrant_strobe,
  output var  logic       read_enable_n,
  output var  logic       output_enable_n,
  output var  logic       expansion_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    queue_address   = 8'h00;
    address_strobe  = 1'b0;
    quadrant_strobe = 1'b0;
    read_enable_n   = 1'b1;
    output_enable_n = 1'b1;
    expansion_in    = 1'b0;
  end

  // ----------------------------------------------------------------
  // selection strobes
  // ----------------------------------------------------------------
  task automatic strobe(input logic quad, input logic [7:0] a);
    @(posedge clk);
    queue_address <= a;
    if (quad) quadrant_strobe <= 1'b1;
    else address_strobe <= 1'b1;
    @(posedge clk);
    address_strobe  <= 1'b0;
    quadrant_strobe <= 1'b0;
    // stale address is not kept, so a late sample cannot pass by luck
    queue_address   <= ~a;
  endtask

  // one cycle of read with both enables low
  task automatic pulse_read();
    @(posedge clk);
    read_enable_n   <= 1'b0;
    output_enable_n <= 1'b0;
    @(posedge clk);
    read_enable_n   <= 1'b1;
    output_enable_n <= 1'b1;
  endtask

  task automatic set_exp(input logic v);
    @(posedge clk);
    expansion_in <= v;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_mq_read_port.sv
// self-checking bench for the multi-queue read port
`default_nettype none
module tb_mq_read_port;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] DEV_ID = 3'h2;
  localparam logic [4:0] QSEL   = 5'h05;

  logic        clk_sys, rst;
  logic [7:0]  qaddr;
  logic        astb, qstb, ren_n, oe_n, exp_in;
  logic [35:0] read_data;
  logic        ov_n, ae_n, pr_n, sync, exp_out, done_n, irq;
  logic [7:0]  bus_n;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          n_mismatch, checked, n;
  logic [31:0] ctrl_val;
  logic [35:0] w;

  mq_read_port i_mq_read_port (
    .CLK_SYS(clk_sys), .RST(rst), .READ_QUEUE_ADDRESS(qaddr), .READ_ADDRESS_STROBE(astb),
    .FLAG_QUADRANT_STROBE(qstb), .READ_ENABLE_N(ren_n), .OUTPUT_ENABLE_N(oe_n), .EXPANSION_IN(exp_in),
    .READ_DATA(read_data), .OUTPUT_VALID_FLAG_N(ov_n), .ALMOST_EMPTY_FLAG_N(ae_n), .PACKET_READY_FLAG_N(pr_n),
    .ALMOST_EMPTY_READY_BUS_N(bus_n), .FLAG_BUS_SYNC(sync), .EXPANSION_OUT(exp_out),
    .PROGRAM_DONE_OUT_N(done_n), .IRQ(irq), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
    .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid),
    .RREADY(rready), .RDATA(rdata), .RRESP(rresp));

  host_read_model i_host_read_model (
    .clk(clk_sys), .queue_address(qaddr), .address_strobe(astb), .quadrant_strobe(qstb),
    .read_enable_n(ren_n), .output_enable_n(oe_n), .expansion_in(exp_in));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && k < 100);
    // a response that never comes is a failure, not a silent return
    if (bvalid !== 1'b1) n_mismatch++;
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && k < 100);
    if (rvalid !== 1'b1) n_mismatch++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [35:0] word(input int i);
    return {4'(i + 1), 32'hc0de_0000 + 32'(i)};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    axi_read(mq_read_pkg::OFS_CTRL, rd, rs);
    chk("ctrl reset", 36'(mq_read_pkg::CTRL_RST), 36'(rd));
    axi_read(mq_read_pkg::OFS_LEVELS, rd, rs);
    chk("levels reset", 36'(mq_read_pkg::LEVELS_RST), 36'(rd));
    axi_read(8'h1c, rd, rs);
    chk("unmapped read resp", 36'(mq_read_pkg::RESP_SLVERR), 36'(rs));
    axi_write(8'h20, 32'hffff_ffff, rs);
    chk("unmapped write resp", 36'(mq_read_pkg::RESP_SLVERR), 36'(rs));
    ctrl_val = (32'h1 << mq_read_pkg::CTRL_DONE_BIT) | (32'(DEV_ID) << mq_read_pkg::CTRL_ID_LSB);
    axi_write(mq_read_pkg::OFS_CTRL, ctrl_val, rs);
    chk("ctrl write resp", 36'(mq_read_pkg::RESP_OKAY), 36'(rs));
    // done output follows the control register one edge later
    @(posedge clk_sys);
    chk("program done", 36'h0, 36'(done_n));
    for (int i = 0; i < 3; i++) begin
      w = word(i);
      axi_write(mq_read_pkg::OFS_PUSH_LO, w[31:0], rs);
      axi_write(mq_read_pkg::OFS_PUSH_CMD, (32'(QSEL) << mq_read_pkg::CMD_QUEUE_LSB) | 32'(w[35:32]), rs);
    end
    // select with read enable off, only after programming is done
    i_host_read_model.strobe(1'b0, {DEV_ID, QSEL});
    n = 0;
    while (ov_n !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk("first word", word(0), read_data);
    chk("valid flag", 36'h0, 36'(ov_n));
    chk("expansion out", 36'h1, 36'(exp_out));
    // two words left: above almost-empty level 1, below packet-ready level 3
    chk("ae flag above level", 36'h1, 36'(ae_n));
    chk("pr flag below level", 36'h1, 36'(pr_n));
    // only the selected queue holds more words than the almost-empty level
    chk("flag bus quadrant 0", 36'(32'h1 << QSEL), 36'(bus_n));
    repeat (6) @(posedge clk_sys);
    chk("held word", word(0), read_data);
    i_host_read_model.pulse_read();
    repeat (5) @(posedge clk_sys);
    chk("next word", word(1), read_data);
    chk("ae flag at level", 36'h0, 36'(ae_n));
    // almost-empty level 0 and packet-ready level 1 with one word left
    axi_write(mq_read_pkg::OFS_LEVELS, 32'h1 << mq_read_pkg::LVL_PR_LSB, rs);
    repeat (2) @(posedge clk_sys);
    chk("pr flag at level", 36'h0, 36'(pr_n));
    chk("ae flag level zero", 36'h1, 36'(ae_n));
    axi_read(mq_read_pkg::OFS_IRQ_STATUS, rd, rs);
    chk("select event", 36'h1, 36'(rd[mq_read_pkg::EV_SELECT]));
    chk("irq masked", 36'h0, 36'(irq));
    axi_write(mq_read_pkg::OFS_IRQ_MASK, 32'h0000_0001, rs);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", 36'h1, 36'(irq));
    axi_write(mq_read_pkg::OFS_IRQ_STATUS, 32'h0000_0001, rs);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 36'h0, 36'(irq));
    // middle address bits set to show they are ignored
    i_host_read_model.strobe(1'b1, {DEV_ID, 3'h7, 2'h3});
    repeat (5) @(posedge clk_sys);
    axi_read(mq_read_pkg::OFS_STATUS, rd, rs);
    chk("quadrant", 36'h3, 36'(rd[7:6]));
    // queues 24 to 31 are empty, so every flag of quadrant 3 is low
    chk("flag bus quadrant 3", 36'h0, 36'(bus_n));
    i_host_read_model.set_exp(1'b1);
    repeat (5) @(posedge clk_sys);
    chk("expansion yield", 36'h0, 36'(exp_out));
    i_host_read_model.strobe(1'b0, {DEV_ID + 3'h1, QSEL});
    repeat (5) @(posedge clk_sys);
    axi_read(mq_read_pkg::OFS_STATUS, rd, rs);
    chk("foreign id deselects", 36'h0, 36'(rd[5]));
    axi_write(mq_read_pkg::OFS_CTRL, ctrl_val | 32'h1, rs);
    n = 0;
    while (sync !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk("sync seen", 36'h1, 36'(sync));
    @(posedge clk_sys);
    chk("sync pulse", 36'h0, 36'(sync));
    repeat (3) @(posedge clk_sys);
    chk("sync period", 36'h1, 36'(sync));
    test_done();
  end
endmodule
`default_nettype wire
